/* File: pkg/fabric_pkg.sv */
// Constants shared by the core memory bus fabric and its address decoder.
// Assumes a single 20 MHz system clock for every bus.
package fabric_pkg;
  localparam int unsigned PROG_ADDR_W   = 21;
  localparam int unsigned PROG_DATA_W   = 16;
  localparam int unsigned DATA_ADDR_W   = 24;
  localparam int unsigned WIDE_DATA_W   = 32;
  localparam int unsigned NARROW_DATA_W = 16;
  localparam int unsigned PERIPH_W      = 16;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned READ_LAT_CYC  = 1;

  // Address window of the memory-mapped peripheral registers (word addresses)
  localparam logic [23:0] PERIPH_BASE   = 24'h00f000;
  localparam logic [23:0] PERIPH_LIMIT  = 24'h00ffff;
  localparam int unsigned ADDR_MSB      = 23;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } acc_size_t;

  typedef enum logic [1:0] {
    TGT_NONE   = 2'h0,
    TGT_DMEM   = 2'h1,
    TGT_PERIPH = 2'h3
  } target_t;

  localparam logic [23:0] RESET_ADDR = 24'h000000;
  localparam logic [31:0] RESET_DATA = 32'h00000000;
endpackage : fabric_pkg

/* File: core/addr_decode.sv */
// Primary-path address decoder: byte restriction and target selection.
// Assumes the address is stable for the cycle in which it is decoded.
`timescale 1ns/1ps
module addr_decode
  import fabric_pkg::*;
(
  input  wire logic [23:0] addr_in,    // Raw primary address
  input  wire acc_size_t   size_in,    // Access size
  input  wire logic        valid_in,   // Access present
  output logic      [23:0] addr_out,   // Address after byte restriction
  output target_t          target      // Selected target
);
  always_comb begin
    addr_out = addr_in;
    // Byte accesses live only in the lower half of the space
    if (size_in == SIZE_BYTE) begin
      addr_out[ADDR_MSB] = 1'b0;
    end
    if (!valid_in) begin
      target = TGT_NONE;
    end else if (addr_out >= PERIPH_BASE && addr_out <= PERIPH_LIMIT) begin
      target = TGT_PERIPH;
    end else begin
      target = TGT_DMEM;
    end
  end
endmodule : addr_decode

/* File: core/core_memory_bus_fabric.sv */
// Bus fabric joining the core to program memory, data memories and the
// peripheral register bus. Assumes synchronous memories with one cycle of
// read latency and peripherals that answer with the same one cycle of read latency.
`timescale 1ns/1ps
module core_memory_bus_fabric
  import fabric_pkg::*;
(
  input  wire logic        clk,                 // System clock
  input  wire logic        rst,                 // Async reset, active high
  // ***** Core program side *****
  input  wire logic [20:0] prog_addr,           // Program address
  input  wire logic        prog_rd,             // Program read / fetch
  input  wire logic        prog_wr,             // Program write
  output logic      [15:0] prog_rdata,          // Program read data
  // ***** Core primary side *****
  input  wire logic [23:0] primary_addr_bus,    // Primary data address
  input  wire acc_size_t   primary_size,        // Access size
  input  wire logic        primary_rd,          // Primary read
  input  wire logic        primary_wr,          // Primary write
  input  wire logic [31:0] primary_wdata,       // Primary write data
  output logic      [31:0] primary_rdata,       // Primary read data
  // ***** Core secondary side *****
  input  wire logic [23:0] secondary_addr_bus,  // Secondary address
  input  wire logic        secondary_rd,        // Secondary read
  output logic      [15:0] secondary_read_bus,  // Secondary read data
  output logic             secondary_err,       // Secondary size error flag
  // ***** Program memory port *****
  output logic      [20:0] pm_addr,             // Program memory address
  output logic             pm_rd,               // Program memory read
  output logic             pm_wr,               // Program memory write
  output logic      [15:0] pm_wdata,            // Program memory write data
  input  wire logic [15:0] pm_rdata,            // Program memory read data
  // ***** Primary data memory port *****
  output logic      [23:0] dm_addr,             // Data memory address
  output acc_size_t        dm_size,             // Data memory access size
  output logic             dm_rd,               // Data memory read
  output logic             dm_wr,               // Data memory write
  output logic      [31:0] dm_wdata,            // Data memory write data
  input  wire logic [31:0] dm_rdata,            // Data memory read data
  // ***** Secondary data memory port *****
  output logic      [23:0] dm2_addr,            // Secondary memory address
  output logic             dm2_rd,              // Secondary memory read
  input  wire logic [15:0] dm2_rdata,           // Secondary memory read data
  // ***** Peripheral register bus *****
  output logic      [23:0] periph_addr,         // Peripheral address
  output logic             periph_rd,           // Peripheral read strobe
  output logic             periph_wr,           // Peripheral write strobe
  output logic      [15:0] peripheral_reg_bus,  // Peripheral write data
  input  wire logic [15:0] periph_rdata         // Peripheral read data
);
  // ************************************************************
  // Primary decode
  // ************************************************************
  logic [23:0] p_addr;
  target_t     p_tgt;

  addr_decode u_decode (
    .addr_in  (primary_addr_bus),
    .size_in  (primary_size),
    .valid_in (primary_rd | primary_wr),
    .addr_out (p_addr),
    .target   (p_tgt)
  );

  function automatic logic [15:0] low_half(input logic [31:0] w);
    return w[15:0];
  endfunction : low_half

  // ************************************************************
  // Request steering (combinational, no wait states)
  // ************************************************************
  always_comb begin
    pm_addr            = prog_addr;
    pm_rd              = prog_rd;
    pm_wr              = prog_wr;
    pm_wdata           = low_half(primary_wdata);
    dm_addr            = p_addr;
    dm_size            = primary_size;
    dm_rd              = primary_rd && p_tgt == TGT_DMEM;
    dm_wr              = primary_wr && p_tgt == TGT_DMEM;
    dm_wdata           = primary_wdata;
    periph_addr        = p_addr;
    // Same-cycle strobes: the peripheral bus shares the memory clock
    periph_rd          = primary_rd && p_tgt == TGT_PERIPH;
    periph_wr          = primary_wr && p_tgt == TGT_PERIPH;
    peripheral_reg_bus = low_half(primary_wdata);
    // Secondary port is independent, so both reads proceed together
    dm2_addr           = secondary_addr_bus;
    dm2_rd             = secondary_rd;
  end

  // ************************************************************
  // Read return path
  // ************************************************************
  target_t     rtgt_q,  rtgt_d;
  logic        prd_q,   prd_d;
  logic        srd_q,   srd_d;
  logic [15:0] prog_rdata_q, prog_rdata_d;
  logic [31:0] prim_rdata_q, prim_rdata_d;
  logic [15:0] sec_rdata_q,  sec_rdata_d;

  always_comb begin
    rtgt_d       = primary_rd ? p_tgt : TGT_NONE;
    prd_d        = prog_rd;
    srd_d        = secondary_rd;
    prog_rdata_d = prog_rdata_q;
    prim_rdata_d = prim_rdata_q;
    sec_rdata_d  = sec_rdata_q;
    if (prd_q) begin
      prog_rdata_d = pm_rdata;
    end
    case (rtgt_q)
      TGT_DMEM:   prim_rdata_d = dm_rdata;
      // Peripheral data is 16 bits wide; upper half reads zero
      TGT_PERIPH: prim_rdata_d = {16'h0000, periph_rdata};
      default:    prim_rdata_d = prim_rdata_q;
    endcase
    if (srd_q) begin
      sec_rdata_d = dm2_rdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rtgt_q       <= TGT_NONE;
      prd_q        <= 1'b0;
      srd_q        <= 1'b0;
      prog_rdata_q <= RESET_DATA[15:0];
      prim_rdata_q <= RESET_DATA;
      sec_rdata_q  <= RESET_DATA[15:0];
    end else begin
      rtgt_q       <= rtgt_d;
      prd_q        <= prd_d;
      srd_q        <= srd_d;
      prog_rdata_q <= prog_rdata_d;
      prim_rdata_q <= prim_rdata_d;
      sec_rdata_q  <= sec_rdata_d;
    end
  end

  // Captured one cycle after the memory answers; data outputs from flops
  assign prog_rdata         = prog_rdata_q;
  assign primary_rdata      = prim_rdata_q;
  assign secondary_read_bus = sec_rdata_q;

  // ************************************************************
  // Secondary size check
  // ************************************************************
  logic err_q, err_d;

  always_comb begin
    // Secondary path is word only; a secondary read beside a byte or long primary read is flagged
    err_d = secondary_rd && primary_rd && primary_size != SIZE_WORD;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end

  assign secondary_err = err_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_prog_write_low;
    @(posedge clk) disable iff (rst) pm_wr |-> pm_wdata == primary_wdata[15:0];
  endproperty
  a_prog_write_low: assert property (p_prog_write_low) else $error("program write data not low half");

  property p_prog_read;
    @(posedge clk) disable iff (rst) prog_rd ##1 1'b1 |=> prog_rdata == $past(pm_rdata);
  endproperty
  a_prog_read: assert property (p_prog_read) else $error("program read data wrong");

  property p_dm_read;
    @(posedge clk) disable iff (rst) dm_rd ##1 1'b1 |=> primary_rdata == $past(dm_rdata);
  endproperty
  a_dm_read: assert property (p_dm_read) else $error("primary read data wrong");

  property p_size_pass;
    @(posedge clk) disable iff (rst) (dm_rd || dm_wr) |-> dm_size == primary_size;
  endproperty
  a_size_pass: assert property (p_size_pass) else $error("access size not passed");

  property p_periph_sel;
    @(posedge clk) disable iff (rst)
      (primary_rd && primary_size != SIZE_BYTE && primary_addr_bus >= PERIPH_BASE
       && primary_addr_bus <= PERIPH_LIMIT) |-> periph_rd && !dm_rd;
  endproperty
  a_periph_sel: assert property (p_periph_sel) else $error("peripheral not selected");

  property p_sec_read;
    @(posedge clk) disable iff (rst) dm2_rd ##1 1'b1 |=> secondary_read_bus == $past(dm2_rdata);
  endproperty
  a_sec_read: assert property (p_sec_read) else $error("secondary read data wrong");

  property p_sec_err;
    @(posedge clk) disable iff (rst)
      (secondary_rd && primary_rd && primary_size != SIZE_WORD) |=> secondary_err;
  endproperty
  a_sec_err: assert property (p_sec_err) else $error("secondary size error missed");

  property p_periph_nowait;
    @(posedge clk) disable iff (rst) periph_rd ##1 1'b1 |=> primary_rdata == {16'h0000, $past(periph_rdata)};
  endproperty
  a_periph_nowait: assert property (p_periph_nowait) else $error("peripheral read not single cycle");

  property p_periph_wdata;
    @(posedge clk) disable iff (rst) periph_wr |-> peripheral_reg_bus == primary_wdata[15:0];
  endproperty
  a_periph_wdata: assert property (p_periph_wdata) else $error("peripheral write data wrong");

  property p_byte_msb;
    @(posedge clk) disable iff (rst) ((dm_rd || dm_wr) && primary_size == SIZE_BYTE) |-> !dm_addr[ADDR_MSB];
  endproperty
  a_byte_msb: assert property (p_byte_msb) else $error("byte address msb not cleared");

  property p_dual;
    @(posedge clk) disable iff (rst) (dm_rd && secondary_rd) |-> dm2_rd;
  endproperty
  a_dual: assert property (p_dual) else $error("dual read blocked");

  property p_prog_addr;
    @(posedge clk) disable iff (rst) (pm_rd || pm_wr) |-> pm_addr == prog_addr;
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("program address not passed");

  // Hold checks: read data of a path moves only on the second edge after a read of that path
  property p_prog_hold;
    @(posedge clk) disable iff (rst) !prog_rd ##1 1'b1 |=> $stable(prog_rdata);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("program read data moved without a read");

  property p_dm_addr;
    @(posedge clk) disable iff (rst) ((dm_rd || dm_wr) && primary_size != SIZE_BYTE) |-> dm_addr == primary_addr_bus;
  endproperty
  a_dm_addr: assert property (p_dm_addr) else $error("primary address not passed");

  property p_prim_hold;
    @(posedge clk) disable iff (rst) !primary_rd ##1 1'b1 |=> $stable(primary_rdata);
  endproperty
  a_prim_hold: assert property (p_prim_hold) else $error("primary read data moved without a read");

  property p_dm_wdata;
    @(posedge clk) disable iff (rst) dm_wr |-> dm_wdata == primary_wdata && dm_size == primary_size;
  endproperty
  a_dm_wdata: assert property (p_dm_wdata) else $error("primary write data not passed");

  property p_periph_excl;
    @(posedge clk) disable iff (rst) !((periph_rd || periph_wr) && (dm_rd || dm_wr));
  endproperty
  a_periph_excl: assert property (p_periph_excl) else $error("peripheral and memory both strobed");

  property p_sec_addr;
    @(posedge clk) disable iff (rst) secondary_rd |-> dm2_rd && dm2_addr == secondary_addr_bus;
  endproperty
  a_sec_addr: assert property (p_sec_addr) else $error("secondary address not passed");

  property p_sec_hold;
    @(posedge clk) disable iff (rst) !secondary_rd ##1 1'b1 |=> $stable(secondary_read_bus);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("secondary read data moved without a read");

  property p_sec_word_ok;
    @(posedge clk) disable iff (rst) !(secondary_rd && primary_rd && primary_size != SIZE_WORD) |=> !secondary_err;
  endproperty
  a_sec_word_ok: assert property (p_sec_word_ok) else $error("secondary error without cause");

  property p_periph_strobe;
    @(posedge clk) disable iff (rst)
      (periph_rd || periph_wr) |-> periph_rd == primary_rd && periph_wr == primary_wr;
  endproperty
  a_periph_strobe: assert property (p_periph_strobe) else $error("peripheral strobe not same cycle");

  property p_periph_upper;
    @(posedge clk) disable iff (rst) periph_rd ##1 1'b1 |=> primary_rdata[31:16] == 16'h0000;
  endproperty
  a_periph_upper: assert property (p_periph_upper) else $error("peripheral read upper half not zero");

  property p_byte_periph;
    @(posedge clk) disable iff (rst) ((periph_rd || periph_wr) && primary_size == SIZE_BYTE) |-> !periph_addr[ADDR_MSB];
  endproperty
  a_byte_periph: assert property (p_byte_periph) else $error("byte peripheral address msb set");

  property p_byte_low;
    @(posedge clk) disable iff (rst)
      ((dm_rd || dm_wr) && primary_size == SIZE_BYTE) |-> dm_addr[22:0] == primary_addr_bus[22:0];
  endproperty
  a_byte_low: assert property (p_byte_low) else $error("byte address low bits changed");

  property p_dual_data;
    @(posedge clk) disable iff (rst)
      (dm_rd && dm2_rd) ##1 1'b1 |=> primary_rdata == $past(dm_rdata) && secondary_read_bus == $past(dm2_rdata);
  endproperty
  a_dual_data: assert property (p_dual_data) else $error("dual read data wrong");
endmodule : core_memory_bus_fabric

/* File: sim/mem_side_model.sv */
// Far-side model: program, data and secondary memories plus peripheral registers.
// Assumes the fabric's memory strobes are combinational and sampled at each rising clk.
`timescale 1ns/1ps
module mem_side_model (
  input  wire logic        clk,          // System clock
  input  wire logic [20:0] pm_addr,      // Program memory address
  input  wire logic        pm_rd,        // Program memory read
  input  wire logic [23:0] dm_addr,      // Data memory address
  input  wire logic        dm_rd,        // Data memory read
  input  wire logic [23:0] dm2_addr,     // Secondary memory address
  input  wire logic        dm2_rd,       // Secondary memory read
  input  wire logic [23:0] periph_addr,  // Peripheral address
  input  wire logic        periph_rd,    // Peripheral read strobe
  output logic      [15:0] pm_rdata,     // Program read data
  output logic      [31:0] dm_rdata,     // Data read data
  output logic      [15:0] dm2_rdata,    // Secondary read data
  output logic      [15:0] periph_rdata  // Peripheral read data
);
  logic [15:0] held_q;
  initial {pm_rdata, dm_rdata, dm2_rdata, held_q} = 80'h0;
  // Idle buses toggle, so a fabric that samples late never sees a stale match
  always @(posedge clk) begin
    pm_rdata  <= pm_rd ? (pm_addr[15:0] ^ 16'h1234) : ~pm_rdata;
    dm_rdata  <= dm_rd ? {dm_addr[15:0] ^ 16'h5a5a, dm_addr[23:8]} : ~dm_rdata;
    dm2_rdata <= dm2_rd ? ~dm2_addr[15:0] : ~dm2_rdata;
    held_q    <= periph_rd ? (periph_addr[15:0] ^ 16'hc3c3) : ~held_q;
  end
  // Registers answer on the edge after the strobe, like data memory, so back-to-back reads stay apart
  assign periph_rdata = held_q;
endmodule : mem_side_model

/* File: sim/core_memory_bus_fabric_bench.sv */
// Self-checking bench for the core memory bus fabric.
// Assumes mem_side_model answers every memory port; inputs change on falling clk.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module core_memory_bus_fabric_bench;
  import fabric_pkg::*;
  logic clk = 1'b0, rst = 1'b1, prog_rd = 1'b0, prog_wr = 1'b0;
  logic primary_rd = 1'b0, primary_wr = 1'b0, secondary_rd = 1'b0;
  logic [20:0] prog_addr = 21'h0, pm_addr;
  logic [23:0] primary_addr_bus = 24'h0, secondary_addr_bus = 24'h0, dm_addr, dm2_addr, periph_addr;
  logic [31:0] primary_wdata = 32'h0, primary_rdata, dm_wdata, dm_rdata;
  logic [15:0] prog_rdata, secondary_read_bus, pm_wdata, pm_rdata, dm2_rdata, peripheral_reg_bus, periph_rdata;
  logic        secondary_err, pm_rd, pm_wr, dm_rd, dm_wr, dm2_rd, periph_rd, periph_wr;
  acc_size_t   primary_size = SIZE_WORD, dm_size;
  int          errors = 0, n_tests = 0;

  always #25 clk = ~clk;
  core_memory_bus_fabric dut_u (
    .clk(clk), .rst(rst),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_wr(prog_wr), .prog_rdata(prog_rdata),
    .primary_addr_bus(primary_addr_bus), .primary_size(primary_size), .primary_rd(primary_rd),
    .primary_wr(primary_wr), .primary_wdata(primary_wdata), .primary_rdata(primary_rdata),
    .secondary_addr_bus(secondary_addr_bus), .secondary_rd(secondary_rd),
    .secondary_read_bus(secondary_read_bus), .secondary_err(secondary_err),
    .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_size(dm_size), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata), .dm2_addr(dm2_addr), .dm2_rd(dm2_rd), .dm2_rdata(dm2_rdata),
    .periph_addr(periph_addr), .periph_rd(periph_rd), .periph_wr(periph_wr),
    .peripheral_reg_bus(peripheral_reg_bus), .periph_rdata(periph_rdata)
  );
  mem_side_model model_u (
    .clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .dm_addr(dm_addr), .dm_rd(dm_rd),
    .dm2_addr(dm2_addr), .dm2_rd(dm2_rd), .periph_addr(periph_addr), .periph_rd(periph_rd),
    .pm_rdata(pm_rdata), .dm_rdata(dm_rdata), .dm2_rdata(dm2_rdata), .periph_rdata(periph_rdata)
  );

  // ****************************************
  // Expectations
  // ****************************************
  function automatic logic [23:0] eff(input logic [23:0] a, input acc_size_t s);
    return (s == SIZE_BYTE) ? {1'b0, a[22:0]} : a;
  endfunction : eff
  function automatic logic is_per(input logic [23:0] a);
    return (a >= PERIPH_BASE) && (a <= PERIPH_LIMIT);
  endfunction : is_per
  function automatic logic [31:0] exp_rd(input logic [23:0] a);
    return is_per(a) ? {16'h0, a[15:0] ^ 16'hc3c3} : {a[15:0] ^ 16'h5a5a, a[23:8]};
  endfunction : exp_rd

  // ****************************************
  // Drivers
  // ****************************************
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic idle;
    @(negedge clk);
    {primary_rd, primary_wr, prog_rd, prog_wr, secondary_rd} = 5'h0;
  endtask : idle
  task automatic req(input logic rd, wr, input logic [23:0] a, input acc_size_t s,
                     input logic sec, input logic [23:0] sa, input logic [20:0] pa, input logic [31:0] wd);
    logic [23:0] e;
    e = eff(a, s);
    @(negedge clk);
    {primary_rd, prog_rd, primary_wr, prog_wr, secondary_rd} = {rd, rd, wr, wr, sec};
    primary_addr_bus   = a;
    primary_size       = s;
    secondary_addr_bus = sa;
    prog_addr          = pa;
    primary_wdata      = wd;
    #1;
    `CHK(is_per(e) ? periph_addr : dm_addr, e)
    `CHK(dm_rd, rd & ~is_per(e))
    `CHK(periph_rd, rd & is_per(e))
    `CHK(dm_wr, wr & ~is_per(e))
    `CHK(periph_wr, wr & is_per(e))
    `CHK(dm_size, s)
    `CHK(dm_wdata, wd)
    `CHK(peripheral_reg_bus, wd[15:0])
    `CHK(pm_wdata, wd[15:0])
    `CHK({pm_addr, pm_rd, pm_wr}, {pa, rd, wr})
    `CHK({dm2_addr, dm2_rd}, {sa, sec})
  endtask : req
  task automatic rd_chk(input logic [23:0] a, input acc_size_t s, input logic sec,
                        input logic [23:0] sa, input logic [20:0] pa);
    req(1'b1, 1'b0, a, s, sec, sa, pa, 32'h0);
    idle();
    `CHK(secondary_err, sec & (s != SIZE_WORD))
    idle();
    `CHK(primary_rdata, exp_rd(eff(a, s)))
    `CHK(prog_rdata, pa[15:0] ^ 16'h1234)
    `CHK(secondary_err, 1'b0)
    if (sec) `CHK(secondary_read_bus, ~sa[15:0])
  endtask : rd_chk

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
  initial begin
    logic [23:0] a;
    acc_size_t   s;
    void'($urandom(32'h6e19));
    repeat (6) @(negedge clk);
    `CHK({primary_rdata, prog_rdata, secondary_read_bus, secondary_err}, 65'h0)
    repeat (7) @(negedge clk);
    rst = 1'b0;
    $display("test reset done");
    rd_chk(24'h80f010, SIZE_BYTE, 1'b1, 24'h000300, 21'h1fffff);
    rd_chk(24'hffffff, SIZE_BYTE, 1'b0, 24'h0, 21'h0);
    rd_chk(24'h00f0fe, SIZE_WORD, 1'b1, 24'h00a5a5, 21'h00777);
    rd_chk(24'h123456, SIZE_LONG, 1'b1, 24'hfedcba, 21'h10001);
    $display("test corners done");
    req(1'b1, 1'b0, 24'h000100, SIZE_LONG, 1'b1, 24'h000200, 21'h1, 32'h0);
    req(1'b1, 1'b0, 24'h000104, SIZE_WORD, 1'b1, 24'h000202, 21'h2, 32'h0);
    idle();
    `CHK(primary_rdata, exp_rd(24'h000100))
    `CHK(secondary_read_bus, ~16'h0200)
    idle();
    `CHK(primary_rdata, exp_rd(24'h000104))
    `CHK(secondary_read_bus, ~16'h0202)
    req(1'b1, 1'b0, 24'h00f010, SIZE_WORD, 1'b0, 24'h0, 21'h3, 32'h0);
    req(1'b1, 1'b0, 24'h00f012, SIZE_WORD, 1'b0, 24'h0, 21'h4, 32'h0);
    idle();
    `CHK(primary_rdata, exp_rd(24'h00f010))
    idle();
    `CHK(primary_rdata, exp_rd(24'h00f012))
    $display("test back_to_back done");
    // Random mix sets bits 22:12 to 00f on half of draws, in the peripheral window when bit 23 is clear or the access is byte
    for (int i = 0; i < 30; i++) begin
      a = 24'($urandom);
      if ($urandom_range(1)) a[22:12] = 11'h00f;
      s = acc_size_t'($urandom_range(2));
      if (i % 2 == 1) rd_chk(a, s, 1'($urandom), 24'($urandom), 21'($urandom));
      else begin
        req(1'b0, 1'b1, a, s, 1'b0, 24'h0, 21'($urandom), $urandom);
        idle();
      end
    end
    $display("test random done");
    give_verdict();
  end
endmodule : core_memory_bus_fabric_bench
